// ==== swr_regs.svh ====
// Register map, field positions, reset values and codes of the wake-up and reset-flag block
// Function
// - Edge status valid only in both-edges mode
// - Edge status read-only: 01 rise, 10 fall
// - Request clear also clears edge status
// - NMI flag bit 1 marks pin source
// - NMI flag bit 0 marks watchdog source
// - NMI flag read returns then clears flags
// - Cause bit 4 set by debug reset request
// - Cause bit 3 set by backup exit
// - Cause bit 2 set by watchdog reset
// - Cause bit 1 set by reset pin
// - Cause bit 0 set by power-on reset
// - Cause register initialised only by power-on
// - Power-on bit set only by power-on reset
// - Cause bits 4 to 1 cleared only by writing zero or by power-on reset
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH

// ============================================================
// Byte offsets
`define SWR_OFS_MODE     12'h000
`define SWR_OFS_CLEAR    12'h004
`define SWR_OFS_NMI      12'h008
`define SWR_OFS_CAUSE    12'h00C
`define SWR_OFS_ISTAT    12'h010
`define SWR_OFS_IMASK    12'h014

// ============================================================
// Mode register fields (key source high half, rtc source low half)
`define SWR_KEY_LVL_LSB  12
`define SWR_KEY_EDGE_LSB 10
`define SWR_KEY_EN_BIT   8
`define SWR_RTC_LVL_LSB  4
`define SWR_RTC_EDGE_LSB 2
`define SWR_RTC_EN_BIT   0
`define SWR_LVL_RESET    3'h2

// ============================================================
// Clear codes and reset values
`define SWR_CLR_EXT_MAX  5'h07
`define SWR_CLR_KEY      5'h08
`define SWR_CLR_RTC      5'h09
`define SWR_CAUSE_INIT   5'h01
`define SWR_IRQ_N        4

`endif

// ==== swr_pkg.sv ====
// Types shared by the wake-up and reset-flag block
`default_nettype none
package swr_pkg;

    // Level select codes of a standby release source
    typedef enum logic [2:0] {
        SWR_LVL_LOW  = 3'b000,
        SWR_LVL_HIGH = 3'b001,
        SWR_LVL_FALL = 3'b010,
        SWR_LVL_RISE = 3'b011,
        SWR_LVL_BOTH = 3'b100
    } swr_level_t;

    // Per-source configuration and captured edge
    typedef struct packed {
        swr_level_t  level;
        logic [1:0]  edge_seen;
        logic        enable;
    } swr_src_t;

    // Reset cause events, one pulse per reset kind
    typedef struct packed {
        logic debug_req;
        logic backup_exit;
        logic watchdog;
        logic pin;
    } swr_rst_ev_t;

endpackage
`default_nettype wire

// ==== swr_top.sv ====
// Standby wake-up mode control, NMI source flags and reset cause flags
`timescale 1ns/1ps
`default_nettype none
`include "swr_regs.svh"

module swr_top
    import swr_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    // Clock, resets, enable
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              poweron_rst,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // Standby release sources
    input  wire logic              key_wakeup_irq,
    input  wire logic              rtc_irq,
    // NMI and reset cause events
    input  wire logic              nmi_pin_event,
    input  wire logic              nmi_wdt_event,
    input  wire swr_rst_ev_t       rst_event,
    // Results
    output var  logic [1:0]        standby_release,
    output var  logic [7:0]        ext_irq_clear,
    output var  logic              irq
);

    // ============================================================
    // Helpers

    // Source condition hit for a level select code
    function automatic logic level_hit(swr_level_t lvl, logic prev, logic cur);
        case (lvl)
            SWR_LVL_LOW:  level_hit = !cur;
            SWR_LVL_HIGH: level_hit = cur;
            SWR_LVL_FALL: level_hit = prev && !cur;
            SWR_LVL_RISE: level_hit = !prev && cur;
            SWR_LVL_BOTH: level_hit = prev ^ cur;
            default:      level_hit = 1'b0;
        endcase
    endfunction

    // Edge code: bit 0 rising, bit 1 falling
    function automatic logic [1:0] edge_code(logic prev, logic cur);
        edge_code = {prev && !cur, !prev && cur};
    endfunction

    // ============================================================
    // State

    logic              rst_any;
    swr_src_t          src [2];
    logic [1:0]        src_in;
    logic [1:0]        src_prev;
    logic [1:0]        hit;
    logic [1:0]        nmi_flags;
    logic [4:0]        cause;
    logic [`SWR_IRQ_N-1:0] istat;
    logic [`SWR_IRQ_N-1:0] imask;
    logic [`SWR_IRQ_N-1:0] ievent;
    logic              done;
    logic              wr;
    logic              rd;
    logic [4:0]        clr_code;
    logic [1:0]        clr_src;
    logic [31:0]       next_rdata;
    logic              next_err;

    assign rst_any  = sys_rst || poweron_rst;
    assign src_in   = {rtc_irq, key_wakeup_irq};
    assign done     = psel && penable && pready;
    assign wr       = done && pwrite;
    assign rd       = done && !pwrite;
    assign clr_code = pwdata[4:0];
    // Source clear strobes: code for key, code for rtc
    assign clr_src[0] = wr && paddr == `SWR_OFS_CLEAR && clr_code == `SWR_CLR_KEY;
    assign clr_src[1] = wr && paddr == `SWR_OFS_CLEAR && clr_code == `SWR_CLR_RTC;

    // Enabled source conditions
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            hit[i] = src[i].enable && level_hit(src[i].level, src_prev[i], src_in[i]);
        end
    end

    assign ievent = {nmi_wdt_event, nmi_pin_event, hit};

    // ============================================================
    // APB response: one wait state, then pready for one cycle
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (paddr)
            `SWR_OFS_MODE:
            begin
                next_rdata[`SWR_KEY_LVL_LSB+:3]  = src[0].level;
                next_rdata[`SWR_KEY_EN_BIT]      = src[0].enable;
                next_rdata[`SWR_RTC_LVL_LSB+:3]  = src[1].level;
                next_rdata[`SWR_RTC_EN_BIT]      = src[1].enable;
                if (src[0].level == SWR_LVL_BOTH)
                begin
                    next_rdata[`SWR_KEY_EDGE_LSB+:2] = src[0].edge_seen;
                end
                if (src[1].level == SWR_LVL_BOTH)
                begin
                    next_rdata[`SWR_RTC_EDGE_LSB+:2] = src[1].edge_seen;
                end
            end
            `SWR_OFS_CLEAR: next_rdata = 32'h0000_0000;
            `SWR_OFS_NMI:   next_rdata[1:0] = nmi_flags;
            `SWR_OFS_CAUSE: next_rdata[4:0] = cause;
            `SWR_OFS_ISTAT: next_rdata[`SWR_IRQ_N-1:0] = istat;
            `SWR_OFS_IMASK: next_rdata[`SWR_IRQ_N-1:0] = imask;
            default:        next_err = 1'b1;
        endcase
    end

    // Response flops
    always_ff @(posedge clock)
    begin
        if (rst_any)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            if (psel && penable && !pready)
            begin
                pready  <= 1'b1;
                prdata  <= next_rdata;
                pslverr <= next_err;
            end
            else
            begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ============================================================
    // Release sources: mode, enable, edge capture, sticky request
    always_ff @(posedge clock)
    begin
        if (rst_any)
        begin
            src_prev        <= 2'b00;
            standby_release <= 2'b00;
            for (int i = 0; i < 2; i++)
            begin
                src[i].level     <= swr_level_t'(`SWR_LVL_RESET);
                src[i].edge_seen <= 2'b00;
                src[i].enable    <= 1'b0;
            end
        end
        else if (ce)
        begin
            src_prev <= src_in;
            for (int i = 0; i < 2; i++)
            begin
                // Clear by code, a new edge in the same cycle still lands
                if (clr_src[i])
                begin
                    src[i].edge_seen   <= 2'b00;
                    standby_release[i] <= 1'b0;
                end
                if (hit[i])
                begin
                    standby_release[i] <= 1'b1;
                    if (src[i].level == SWR_LVL_BOTH)
                    begin
                        src[i].edge_seen <= (clr_src[i] ? 2'b00 : src[i].edge_seen)
                                          | edge_code(src_prev[i], src_in[i]);
                    end
                end
            end
            // Level and enable are software fields; status is not writable
            if (wr && paddr == `SWR_OFS_MODE)
            begin
                src[0].level  <= swr_level_t'(pwdata[`SWR_KEY_LVL_LSB+:3]);
                src[0].enable <= pwdata[`SWR_KEY_EN_BIT];
                src[1].level  <= swr_level_t'(pwdata[`SWR_RTC_LVL_LSB+:3]);
                src[1].enable <= pwdata[`SWR_RTC_EN_BIT];
            end
        end
    end

    // ============================================================
    // External request clear pulses
    always_ff @(posedge clock)
    begin
        if (rst_any)
        begin
            ext_irq_clear <= 8'h00;
        end
        else if (ce)
        begin
            ext_irq_clear <= 8'h00;
            if (wr && paddr == `SWR_OFS_CLEAR && clr_code <= `SWR_CLR_EXT_MAX)
            begin
                ext_irq_clear <= 8'h01 << clr_code[2:0];
            end
        end
    end

    // ============================================================
    // NMI source flags, cleared by the read that returned them
    always_ff @(posedge clock)
    begin
        if (rst_any)
        begin
            nmi_flags <= 2'b00;
        end
        else if (ce)
        begin
            if (rd && paddr == `SWR_OFS_NMI)
            begin
                nmi_flags <= (nmi_flags & ~prdata[1:0])
                           | {nmi_pin_event, nmi_wdt_event};
            end
            else
            begin
                nmi_flags <= nmi_flags | {nmi_pin_event, nmi_wdt_event};
            end
        end
    end

    // ============================================================
    // Reset cause flags, kept through every reset but power-on
    always_ff @(posedge clock)
    begin
        if (poweron_rst)
        begin
            cause <= `SWR_CAUSE_INIT;
        end
        else if (ce)
        begin
            if (wr && paddr == `SWR_OFS_CAUSE)
            begin
                cause <= (cause & pwdata[4:0])
                       | {rst_event.debug_req, rst_event.backup_exit,
                          rst_event.watchdog, rst_event.pin, 1'b0};
            end
            else
            begin
                cause <= cause | {rst_event.debug_req, rst_event.backup_exit,
                                  rst_event.watchdog, rst_event.pin, 1'b0};
            end
        end
    end

    // ============================================================
    // Interrupt status, mask and output
    always_ff @(posedge clock)
    begin
        if (rst_any)
        begin
            istat <= '0;
            imask <= '0;
            irq   <= 1'b0;
        end
        else if (ce)
        begin
            if (wr && paddr == `SWR_OFS_ISTAT)
            begin
                istat <= (istat & ~pwdata[`SWR_IRQ_N-1:0]) | ievent;
            end
            else
            begin
                istat <= istat | ievent;
            end
            if (wr && paddr == `SWR_OFS_IMASK)
            begin
                imask <= pwdata[`SWR_IRQ_N-1:0];
            end
            irq <= |(istat & imask);
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst_any);

    a_edge_only_both: assert property (
        ce && src[0].level != SWR_LVL_BOTH
        |=> (src[0].edge_seen & ~$past(src[0].edge_seen)) == 2'b00)
        else $error("edge status changed outside both-edges mode");

    a_edge_rise_code: assert property (
        ce && src[0].level == SWR_LVL_BOTH && src[0].enable && !src_prev[0] && src_in[0]
        |=> src[0].edge_seen[0])
        else $error("rising edge not recorded");

    a_clear_edge: assert property (
        ce && wr && paddr == `SWR_OFS_CLEAR && clr_code == `SWR_CLR_KEY
        && src_prev[0] == src_in[0] |=> src[0].edge_seen == 2'b00)
        else $error("edge status not cleared");

    a_nmi_pin_flag: assert property (
        ce && nmi_pin_event |=> nmi_flags[1])
        else $error("pin nmi flag not set");

    a_nmi_wdt_flag: assert property (
        ce && nmi_wdt_event |=> nmi_flags[0])
        else $error("watchdog nmi flag not set");

    a_nmi_read_clear: assert property (
        ce && rd && paddr == `SWR_OFS_NMI && !nmi_pin_event && !nmi_wdt_event
        ##1 1'b1 |-> (nmi_flags & $past(prdata[1:0])) == 2'b00)
        else $error("nmi flags not cleared by read");

    a_cause_debug: assert property (
        ce && rst_event.debug_req && !poweron_rst |=> cause[4])
        else $error("debug reset cause not set");

    a_cause_pin: assert property (
        ce && rst_event.pin && !poweron_rst |=> cause[1])
        else $error("pin reset cause not set");

    a_cause_poweron: assert property (@(posedge clock) disable iff (1'b0)
        poweron_rst |=> cause == `SWR_CAUSE_INIT)
        else $error("power-on cause not initialised");

    a_cause_keep: assert property (@(posedge clock) disable iff (1'b0)
        sys_rst && !poweron_rst && rst_event == '0 |=> cause == $past(cause))
        else $error("cause changed by non power-on reset");

    a_clear_pulse: assert property (
        ce && wr && paddr == `SWR_OFS_CLEAR && clr_code <= `SWR_CLR_EXT_MAX
        |=> ext_irq_clear == (8'h01 << $past(clr_code[2:0])) ##1 ext_irq_clear == 8'h00
            || !ce)
        else $error("clear pulse wrong");

    a_release_gate: assert property (
        ce && !src[0].enable && !standby_release[0] |=> !standby_release[0])
        else $error("disabled source released standby");

endmodule
`default_nettype wire

// ==== test_standby_wakeup_and_reset_flags.sv ====
// Testbench of the standby wake-up, NMI flag and reset cause block
`timescale 1ns/1ps
`default_nettype none
`include "swr_regs.svh"

module test_standby_wakeup_and_reset_flags
    import swr_pkg::*;
;
    // ============================================================
    // Signals
    logic        clock           = 1'b0;
    logic        sys_rst         = 1'b1;
    logic        poweron_rst     = 1'b1;
    logic        ce              = 1'b1;
    logic        psel            = 1'b0;
    logic        penable         = 1'b0;
    logic        pwrite          = 1'b0;
    logic [11:0] paddr           = 12'h000;
    logic [31:0] pwdata          = 32'h0000_0000;
    logic        key_wakeup_irq  = 1'b0;
    logic        rtc_irq         = 1'b0;
    logic        nmi_pin_event   = 1'b0;
    logic        nmi_wdt_event   = 1'b0;
    swr_rst_ev_t rst_event       = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  standby_release;
    logic [7:0]  ext_irq_clear;
    logic        irq;
    logic [31:0] rdata;
    logic        serr;
    int          errors          = 0;
    int          compares        = 0;

    // Clock
    always #5 clock = ~clock;

    swr_top u_swr_top (
        .clock(clock), .sys_rst(sys_rst), .poweron_rst(poweron_rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_wakeup_irq(key_wakeup_irq), .rtc_irq(rtc_irq),
        .nmi_pin_event(nmi_pin_event), .nmi_wdt_event(nmi_wdt_event),
        .rst_event(rst_event), .standby_release(standby_release),
        .ext_irq_clear(ext_irq_clear), .irq(irq)
    );

    // ============================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One APB transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            errors++;
        rdata = prdata;
        serr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rdata, exp);
    endtask

    // One-cycle pulse on {nmi pin, nmi watchdog, reset events}
    task automatic pulse(input logic [5:0] v);
        {nmi_pin_event, nmi_wdt_event, rst_event} <= v;
        @(posedge clock);
        {nmi_pin_event, nmi_wdt_event, rst_event} <= 6'h00;
    endtask

    // ============================================================
    // Tests
    initial
    begin
        repeat (10) @(posedge clock);
        sys_rst     <= 1'b0;
        poweron_rst <= 1'b0;
        rd(`SWR_OFS_CAUSE, 32'h0000_0001, "cause power-on");
        rd(`SWR_OFS_MODE, 32'h0000_2020, "mode reset");
        // Each reset kind sets its own cause bit
        apb(1'b1, `SWR_OFS_CAUSE, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            pulse(6'(1 << i));
            rd(`SWR_OFS_CAUSE, 32'(2 << i), "cause bit");
            apb(1'b1, `SWR_OFS_CAUSE, 32'h0000_0000);
        end
        // Writing ones never sets, zeros clear
        pulse(6'h0F);
        apb(1'b1, `SWR_OFS_CAUSE, 32'h0000_001F);
        rd(`SWR_OFS_CAUSE, 32'h0000_001E, "cause ones");
        apb(1'b1, `SWR_OFS_CAUSE, 32'h0000_0010);
        rd(`SWR_OFS_CAUSE, 32'h0000_0010, "cause partial");
        // Pin reset keeps the cause register, returns the mode register to its reset value
        pulse(6'h01);
        apb(1'b1, `SWR_OFS_MODE, 32'h0000_4040);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        rd(`SWR_OFS_CAUSE, 32'h0000_0012, "cause kept");
        rd(`SWR_OFS_MODE, 32'h0000_2020, "mode after pin reset");
        // Power-on reset starts the cause register afresh
        poweron_rst <= 1'b1;
        @(posedge clock);
        poweron_rst <= 1'b0;
        rd(`SWR_OFS_CAUSE, 32'h0000_0001, "cause power-on again");
        // NMI sources, cleared by the read
        pulse(6'h20);
        rd(`SWR_OFS_NMI, 32'h0000_0002, "nmi pin");
        rd(`SWR_OFS_NMI, 32'h0000_0000, "nmi cleared");
        pulse(6'h10);
        rd(`SWR_OFS_NMI, 32'h0000_0001, "nmi wdt");
        pulse(6'h30);
        rd(`SWR_OFS_NMI, 32'h0000_0003, "nmi both");
        rd(`SWR_OFS_NMI, 32'h0000_0000, "nmi cleared");
        // Clock enable low freezes the flags
        ce <= 1'b0;
        pulse(6'h20);
        ce <= 1'b1;
        rd(`SWR_OFS_NMI, 32'h0000_0000, "nmi frozen");
        // Every external clear code
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, `SWR_OFS_CLEAR, 32'(c));
            #1;
            check("ext clear", {24'h0, ext_irq_clear}, 32'(1 << c));
        end
        rd(`SWR_OFS_CLEAR, 32'h0000_0000, "clear reads");
        // Both-edges mode, level first, enable later
        apb(1'b1, `SWR_OFS_MODE, 32'h0000_4C4C);
        rd(`SWR_OFS_MODE, 32'h0000_4040, "edge not writable");
        key_wakeup_irq <= 1'b1;
        rtc_irq        <= 1'b1;
        repeat (4) @(posedge clock);
        check("release disabled", {30'h0, standby_release}, 32'h0000_0000);
        key_wakeup_irq <= 1'b0;
        rtc_irq        <= 1'b0;
        repeat (3) @(posedge clock);
        apb(1'b1, `SWR_OFS_CLEAR, 32'(`SWR_CLR_KEY));
        apb(1'b1, `SWR_OFS_CLEAR, 32'(`SWR_CLR_RTC));
        apb(1'b1, `SWR_OFS_MODE, 32'h0000_4141);
        key_wakeup_irq <= 1'b1;
        rtc_irq        <= 1'b1;
        repeat (3) @(posedge clock);
        key_wakeup_irq <= 1'b0;
        rtc_irq        <= 1'b0;
        repeat (3) @(posedge clock);
        rd(`SWR_OFS_MODE, 32'h0000_4D4D, "edge status");
        check("release enabled", {30'h0, standby_release}, 32'h0000_0003);
        // Stored edge status hidden outside both-edges mode
        apb(1'b1, `SWR_OFS_MODE, 32'h0000_3041);
        rd(`SWR_OFS_MODE, 32'h0000_304D, "edge hidden");
        apb(1'b1, `SWR_OFS_MODE, 32'h0000_4041);
        rd(`SWR_OFS_MODE, 32'h0000_4C4D, "edge shown again");
        apb(1'b1, `SWR_OFS_MODE, 32'h0000_4141);
        apb(1'b1, `SWR_OFS_CLEAR, 32'(`SWR_CLR_KEY));
        rd(`SWR_OFS_MODE, 32'h0000_414D, "key status cleared");
        check("key release cleared", {30'h0, standby_release}, 32'h0000_0002);
        apb(1'b1, `SWR_OFS_CLEAR, 32'(`SWR_CLR_RTC));
        rd(`SWR_OFS_MODE, 32'h0000_4141, "rtc status cleared");
        // Rising mode hides the edge status
        apb(1'b1, `SWR_OFS_MODE, 32'h0000_3041);
        apb(1'b1, `SWR_OFS_MODE, 32'h0000_3141);
        key_wakeup_irq <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`SWR_OFS_MODE, 32'h0000_3141, "status hidden");
        check("rising release", {30'h0, standby_release}, 32'h0000_0001);
        // Interrupt raise, mask and clear
        apb(1'b1, `SWR_OFS_ISTAT, 32'h0000_000F);
        rd(`SWR_OFS_ISTAT, 32'h0000_0000, "status empty");
        apb(1'b1, `SWR_OFS_IMASK, 32'h0000_0004);
        pulse(6'h20);
        repeat (2) @(posedge clock);
        #1;
        check("irq raised", {31'h0, irq}, 32'h0000_0001);
        rd(`SWR_OFS_ISTAT, 32'h0000_0004, "status nmi pin");
        apb(1'b1, `SWR_OFS_IMASK, 32'h0000_0000);
        repeat (2) @(posedge clock);
        #1;
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `SWR_OFS_IMASK, 32'h0000_0004);
        repeat (2) @(posedge clock);
        #1;
        check("irq unmasked", {31'h0, irq}, 32'h0000_0001);
        apb(1'b1, `SWR_OFS_ISTAT, 32'h0000_0004);
        repeat (2) @(posedge clock);
        #1;
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        // Unmapped address
        apb(1'b0, 12'h020, 32'h0000_0000);
        check("unmapped data", rdata, 32'h0000_0000);
        check("unmapped error", {31'h0, serr}, 32'h0000_0001);
        wrap_up;
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        wrap_up;
    end

endmodule
`default_nettype wire
